// *** dcq_params.svh ***
`ifndef DCQ_PARAMS_SVH
`define DCQ_PARAMS_SVH
// Notes on behaviour
// RL1: data word feeds checksum; result due beat setting plus one cycles later
// RL2: checksum holds a 16- or 32-bit value and resets to zero
// RL3: software may seed the checksum register by writing it directly
// RL4: checksum writes are accepted only while the engine is disabled
// RL5: 32-bit mode, not busy: reads return stored value reversed and inverted
// RL6: 16-bit mode or busy: reads return the raw stored value
// RL7: 2-bit fetch priority field steers descriptor fetch priority
// RL8: 2-bit write-back priority field steers descriptor write-back priority
// RL9: busy rises during an update and falls on completion or abort

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCQ_OFF_CTRL    8'h00
`define DCQ_OFF_STATUS  8'h04
`define DCQ_OFF_CHKSUM  8'h08
`define DCQ_OFF_DATAIN  8'h0c
`define DCQ_OFF_QOS     8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCQ_CTRL_EN     0
`define DCQ_CTRL_POLY   1
`define DCQ_CTRL_BEAT   2
`define DCQ_STAT_BUSY   0
`define DCQ_QOS_FETCH   2
`define DCQ_QOS_WB      0

// ----------------------------------------------------------------
// reset values and polynomials
// ----------------------------------------------------------------
`define DCQ_RST_CHKSUM  32'h00000000
`define DCQ_RST_DATAIN  32'h00000000
`define DCQ_RST_QOS     4'h0
`define DCQ_POLY16      32'h00001021
`define DCQ_POLY32      32'h04c11db7

// ----------------------------------------------------------------
// timing: extra cycles beyond the beat setting before a result
// ----------------------------------------------------------------
`define DCQ_LAT_EXTRA   1
`endif

// *** dcq_pkg.sv ***
`include "dcq_params.svh"
package dcq_pkg;
    // engine states, one-hot
    typedef enum logic [1:0] {
        DCQ_IDLE = 2'b01,
        DCQ_RUN  = 2'b10
    } dcq_state_t;

    // register-side state of the top
    typedef struct packed {
        logic        enable;
        logic        poly32;
        logic [1:0]  beat;
        logic [31:0] datain;
        logic [1:0]  fetch;
        logic [1:0]  wback;
        logic [31:0] rdata;
        logic        busy;
    } dcq_top_t;

    // engine state
    typedef struct packed {
        dcq_state_t  st;
        logic [1:0]  cnt;
        logic [1:0]  age;
        logic [1:0]  beat;
        logic [31:0] crc;
        logic [31:0] pend;
    } dcq_eng_t;

    // bit reversal end for end
    function automatic logic [31:0] dcq_rev32(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31 - i];
        end
        return r;
    endfunction

    // checksum over one beat, low byte first; msb-first shifting in 16-bit mode, lsb-first in 32-bit mode
    function automatic logic [31:0] dcq_crc_update(
        input logic [31:0] crc,
        input logic [31:0] data,
        input logic [1:0]  beat,
        input logic        poly32);
        logic [31:0] c;
        logic [31:0] t;
        logic [7:0]  b;
        logic        fb;
        int          nb;
        c  = crc;
        nb = (beat == 2'h0) ? 1 : ((beat == 2'h1) ? 2 : 4);
        for (int k = 0; k < 4; k++) begin
            if (k < nb) begin
                b = data[8*k +: 8];
                if (poly32) begin
                    t = dcq_rev32({b, 24'h0});
                    b = t[7:0];
                end
                for (int i = 7; i >= 0; i--) begin
                    fb = (poly32 ? c[31] : c[15]) ^ b[i];
                    c  = {c[30:0], 1'b0};
                    if (fb) begin
                        c = c ^ (poly32 ? `DCQ_POLY32 : `DCQ_POLY16);
                    end
                end
            end
        end
        if (!poly32) begin
            c = {16'h0, c[15:0]};
        end
        return c;
    endfunction
endpackage

// *** dcq_eng_if.sv ***
interface dcq_eng_if;
    logic        start;   // begin one beat update
    logic [31:0] data;    // beat data
    logic [1:0]  beat;    // beat size setting
    logic        poly32;  // 32-bit polynomial selected
    logic        seed_we; // load seed into checksum
    logic [31:0] seed;    // seed value
    logic        abort;   // drop the update in flight
    logic        busy;    // update in progress
    logic [31:0] crc;     // stored checksum

    modport ctl (output start, data, beat, poly32, seed_we, seed, abort,
                 input  busy, crc);
    modport eng (input  start, data, beat, poly32, seed_we, seed, abort,
                 output busy, crc);
endinterface

// *** dcq_engine.sv ***
`include "dcq_params.svh"
module dcq_engine
    import dcq_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst,      // synchronous reset
    dcq_eng_if.eng   e         // control side
);
    dcq_eng_t s;
    dcq_eng_t next_s;
    logic     commit;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        commit = 1'b0;
        case (s.st)
            DCQ_IDLE: begin
                if (e.seed_we) begin
                    next_s.crc = e.seed; // RL3
                end else if (e.start && !e.abort) begin
                    next_s.st   = DCQ_RUN; // RL9
                    next_s.cnt  = e.beat; // RL1
                    next_s.beat = e.beat;
                    next_s.age  = 2'h0;
                    next_s.pend = dcq_crc_update(s.crc, e.data, e.beat,
                                                 e.poly32); // RL1
                end
            end
            DCQ_RUN: begin
                next_s.age = s.age + 2'h1;
                if (e.abort) begin
                    next_s.st = DCQ_IDLE; // RL9
                end else if (s.cnt == 2'h0) begin
                    commit     = 1'b1;
                    next_s.st  = DCQ_IDLE; // RL9
                    next_s.crc = s.pend; // RL1
                end else begin
                    next_s.cnt = s.cnt - 2'h1;
                end
            end
            default: begin
                next_s.st = DCQ_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s.st   <= DCQ_IDLE;
            s.cnt  <= 2'h0;
            s.age  <= 2'h0;
            s.beat <= 2'h0;
            s.crc  <= `DCQ_RST_CHKSUM; // RL2
            s.pend <= 32'h0;
        end else begin
            s <= next_s;
        end
    end

    assign e.busy = (s.st == DCQ_RUN);
    assign e.crc  = s.crc;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_reset_zero: assert property (@(posedge core_clk) // RL2
        rst |=> (s.crc == 32'h0))
        else $error("checksum not zero after reset");

    chk_commit_time: assert property (@(posedge core_clk) // RL1
        disable iff (rst) commit |-> (s.age == s.beat))
        else $error("result committed at wrong cycle");

    chk_commit_value: assert property (@(posedge core_clk) // RL1
        disable iff (rst) commit |=> (!e.busy && e.crc == $past(s.pend)))
        else $error("committed checksum wrong");

    chk_start_busy: assert property (@(posedge core_clk) // RL9
        disable iff (rst)
        (e.start && !e.busy && !e.abort && !e.seed_we) |=> e.busy)
        else $error("busy did not rise on start");

    chk_abort_idle: assert property (@(posedge core_clk) // RL9
        disable iff (rst) (e.abort && e.busy) |=> (!e.busy && $stable(e.crc)))
        else $error("abort did not end the update");
endmodule

// *** dcq_top.sv ***
// Decided for this implementation: the strobed register port.
`include "dcq_params.svh"
module dcq_top
    import dcq_pkg::*;
(
    input  wire logic        core_clk,           // system clock
    input  wire logic        rst,                // synchronous reset
    input  wire logic [7:0]  addr,               // register byte address
    input  wire logic [31:0] wr_data,            // write data
    input  wire logic        wr_en,              // write strobe
    input  wire logic        rd_en,              // read strobe
    output      logic [31:0] rd_data,            // read data, next cycle
    output      logic [1:0]  fetch_priority,     // descriptor fetch prio
    output      logic [1:0]  writeback_priority, // descriptor write-back prio
    output      logic        crc_busy            // update in progress, one cycle late
);
    dcq_top_t  r;
    dcq_top_t  next_r;
    dcq_eng_if e ();

    logic      wr_ctrl;
    logic      wr_chk;
    logic      wr_din;
    logic      wr_qos;
    logic      rd_chk;
    logic [31:0] chk_view;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign wr_ctrl = wr_en && (addr == `DCQ_OFF_CTRL);
    assign wr_chk  = wr_en && (addr == `DCQ_OFF_CHKSUM);
    assign wr_din  = wr_en && (addr == `DCQ_OFF_DATAIN);
    assign wr_qos  = wr_en && (addr == `DCQ_OFF_QOS);
    assign rd_chk  = rd_en && (addr == `DCQ_OFF_CHKSUM);

    // ----------------------------------------------------------------
    // checksum read formatting
    // ----------------------------------------------------------------
    always_comb begin
        if (r.poly32 && !e.busy) begin
            chk_view = ~dcq_rev32(e.crc); // RL5
        end else begin
            chk_view = e.crc; // RL6
        end
    end

    // ----------------------------------------------------------------
    // engine requests
    // ----------------------------------------------------------------
    always_comb begin
        e.start   = wr_din && r.enable; // RL1
        e.data    = wr_data;
        e.beat    = r.beat;
        e.poly32  = r.poly32;
        e.seed_we = wr_chk && !r.enable; // RL4
        e.seed    = wr_data; // RL3
        e.abort   = wr_ctrl && !wr_data[`DCQ_CTRL_EN];
    end

    // ----------------------------------------------------------------
    // register next state and read mux
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (wr_ctrl) begin
            next_r.enable = wr_data[`DCQ_CTRL_EN];
            next_r.poly32 = wr_data[`DCQ_CTRL_POLY];
            next_r.beat   = wr_data[`DCQ_CTRL_BEAT +: 2];
        end
        if (wr_din) begin
            next_r.datain = wr_data;
        end
        if (wr_qos) begin
            next_r.fetch = wr_data[`DCQ_QOS_FETCH +: 2]; // RL7
            next_r.wback = wr_data[`DCQ_QOS_WB +: 2]; // RL8
        end
        next_r.busy  = e.busy; // RL9
        next_r.rdata = 32'h0;
        if (rd_en) begin
            case (addr)
                `DCQ_OFF_CTRL: begin
                    next_r.rdata[`DCQ_CTRL_EN]      = r.enable;
                    next_r.rdata[`DCQ_CTRL_POLY]    = r.poly32;
                    next_r.rdata[`DCQ_CTRL_BEAT +: 2] = r.beat;
                end
                `DCQ_OFF_STATUS: begin
                    next_r.rdata[`DCQ_STAT_BUSY] = e.busy; // RL9
                end
                `DCQ_OFF_CHKSUM: begin
                    next_r.rdata = chk_view; // RL5
                end
                `DCQ_OFF_DATAIN: begin
                    next_r.rdata = r.datain;
                end
                `DCQ_OFF_QOS: begin
                    next_r.rdata[`DCQ_QOS_FETCH +: 2] = r.fetch;
                    next_r.rdata[`DCQ_QOS_WB +: 2]    = r.wback;
                end
                default: begin
                    next_r.rdata = 32'h0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            r.enable <= 1'b0;
            r.poly32 <= 1'b0;
            r.beat   <= 2'h0;
            r.datain <= `DCQ_RST_DATAIN;
            r.fetch  <= 2'(`DCQ_RST_QOS >> `DCQ_QOS_FETCH);
            r.wback  <= 2'(`DCQ_RST_QOS);
            r.rdata  <= 32'h0;
            r.busy   <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // checksum engine
    // ----------------------------------------------------------------
    dcq_engine u_eng (
        .core_clk (core_clk),
        .rst      (rst),
        .e        (e)
    );

    // ----------------------------------------------------------------
    // outputs, busy delayed by one flop to match the status read path
    // ----------------------------------------------------------------
    assign rd_data            = r.rdata;
    assign fetch_priority     = r.fetch; // RL7
    assign writeback_priority = r.wback; // RL8
    assign crc_busy           = r.busy; // RL9

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_seed_blocked: assert property (@(posedge core_clk) // RL4
        disable iff (rst) (wr_chk && r.enable && !e.busy)
        |=> (e.crc == $past(e.crc)))
        else $error("checksum written while enabled");

    chk_seed_taken: assert property (@(posedge core_clk) // RL3
        disable iff (rst) (wr_chk && !r.enable && !e.busy)
        |=> (e.crc == $past(wr_data)))
        else $error("seed not loaded");

    chk_rev_read: assert property (@(posedge core_clk) // RL5
        disable iff (rst) (rd_chk && r.poly32 && !e.busy)
        |=> (rd_data == ~dcq_rev32($past(e.crc))))
        else $error("32-bit read not reversed and inverted");

    chk_raw_read: assert property (@(posedge core_clk) // RL6
        disable iff (rst) (rd_chk && (!r.poly32 || e.busy))
        |=> (rd_data == $past(e.crc)))
        else $error("raw read altered");

    chk_fetch_prio: assert property (@(posedge core_clk) // RL7
        disable iff (rst) wr_qos
        |=> (fetch_priority == $past(wr_data[3:2])))
        else $error("fetch priority not updated");

    chk_wback_prio: assert property (@(posedge core_clk) // RL8
        disable iff (rst) wr_qos
        |=> (writeback_priority == $past(wr_data[1:0])))
        else $error("write-back priority not updated");

    chk_byte_beat: assert property (@(posedge core_clk) // RL1
        disable iff (rst)
        (e.start && !e.busy && !e.abort && r.beat == 2'h0)
        |=> e.busy ##1 !e.busy)
        else $error("byte beat result not after two cycles");

    chk_busy_flag: assert property (@(posedge core_clk) // RL9
        disable iff (rst) (rd_en && addr == `DCQ_OFF_STATUS)
        |=> (rd_data[0] == $past(e.busy)))
        else $error("status busy mismatch");

    // ----------------------------------------------------------------
    // checks on reset and the output pins
    // ----------------------------------------------------------------
    // every output sits at its reset level after a reset edge
    chk_reset_outputs: assert property (@(posedge core_clk) // RL2
        rst |=> (rd_data == 32'h0 && fetch_priority == 2'h0
                 && writeback_priority == 2'h0 && !crc_busy))
        else $error("outputs not at reset level");

    // busy pin repeats the internal busy one cycle later
    chk_busy_lag: assert property (@(posedge core_clk) // RL9
        disable iff (rst) 1'b1 |=> (crc_busy == $past(e.busy)))
        else $error("busy pin does not follow internal busy");

    // fetch priority only moves on a priority write
    chk_fetch_hold: assert property (@(posedge core_clk) // RL7
        disable iff (rst) !wr_qos |=> $stable(fetch_priority))
        else $error("fetch priority changed without a write");

    // write-back priority only moves on a priority write
    chk_wback_hold: assert property (@(posedge core_clk) // RL8
        disable iff (rst) !wr_qos |=> $stable(writeback_priority))
        else $error("write-back priority changed without a write");

    // ----------------------------------------------------------------
    // checks on the register bus
    // ----------------------------------------------------------------
    // read data stands for one cycle only, zero otherwise
    chk_rdata_quiet: assert property (@(posedge core_clk) // RL5
        disable iff (rst) !rd_en |=> (rd_data == 32'h0))
        else $error("read data did not return to zero");

    // control read returns the stored fields in place
    chk_ctrl_read: assert property (@(posedge core_clk) // RL4
        disable iff (rst) (rd_en && addr == `DCQ_OFF_CTRL)
        |=> (rd_data == {28'h0, $past(r.beat), $past(r.poly32),
                         $past(r.enable)}))
        else $error("control read wrong");

    // control write lands in all three fields
    chk_ctrl_taken: assert property (@(posedge core_clk) // RL4
        disable iff (rst) wr_ctrl
        |=> (r.enable == $past(wr_data[0]) && r.poly32 == $past(wr_data[1])
             && r.beat == $past(wr_data[3:2])))
        else $error("control write not taken");

    // priority read returns both fields in place
    chk_qos_read: assert property (@(posedge core_clk) // RL7
        disable iff (rst) (rd_en && addr == `DCQ_OFF_QOS)
        |=> (rd_data == {28'h0, $past(fetch_priority),
                         $past(writeback_priority)}))
        else $error("priority read wrong");

    // data input word is stored as written
    chk_din_store: assert property (@(posedge core_clk) // RL1
        disable iff (rst) wr_din |=> (r.datain == $past(wr_data)))
        else $error("data input not stored");

    // data input word reads back unchanged
    chk_din_read: assert property (@(posedge core_clk) // RL1
        disable iff (rst) (rd_en && addr == `DCQ_OFF_DATAIN)
        |=> (rd_data == $past(r.datain)))
        else $error("data input read wrong");

    // status read carries nothing but the busy bit
    chk_status_pad: assert property (@(posedge core_clk) // RL9
        disable iff (rst) (rd_en && addr == `DCQ_OFF_STATUS)
        |=> (rd_data[31:1] == 31'h0))
        else $error("status read has stray bits");

    // reads above the map return zero
    chk_unmapped_read: assert property (@(posedge core_clk) // RL6
        disable iff (rst) (rd_en && addr > `DCQ_OFF_QOS)
        |=> (rd_data == 32'h0))
        else $error("unmapped read not zero");

    // ----------------------------------------------------------------
    // checks on the engine requests
    // ----------------------------------------------------------------
    // a data write while disabled starts nothing
    chk_start_refused: assert property (@(posedge core_clk) // RL1
        disable iff (rst) (wr_din && !r.enable && !e.busy) |=> !e.busy)
        else $error("update started while disabled");

    // disabling during an update aborts it
    chk_abort_ctrl: assert property (@(posedge core_clk) // RL9
        disable iff (rst) (wr_ctrl && !wr_data[0] && e.busy) |=> !e.busy)
        else $error("disable did not abort the update");

    // no update outlasts the longest beat
    chk_busy_bound: assert property (@(posedge core_clk) // RL1
        disable iff (rst) $rose(e.busy) |-> ##[1:4] !e.busy)
        else $error("update ran past the longest beat");

    // an idle checksum only moves on a seed write
    chk_crc_hold: assert property (@(posedge core_clk) // RL3
        disable iff (rst) (!e.busy && !wr_chk) |=> $stable(e.crc))
        else $error("checksum changed while idle");
endmodule

// *** dcq_top_tb_top.sv ***
`include "dcq_params.svh"
module dcq_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    `define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
        n_errors++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic [7:0]  addr     = 8'h00;
    logic [31:0] wr_data  = 32'h0;
    logic        wr_en    = 1'b0;
    logic        rd_en    = 1'b0;
    logic [31:0] rd_data;
    logic [1:0]  fetch_priority;
    logic [1:0]  writeback_priority;
    logic        crc_busy;
    int          n_errors = 0;
    int          checked  = 0;
    int          busy_cnt = 0;
    logic [31:0] s;
    logic [31:0] d;
    logic [31:0] e;

    dcq_top dut (
        .core_clk           (core_clk),
        .rst                (rst),
        .addr               (addr),
        .wr_data            (wr_data),
        .wr_en              (wr_en),
        .rd_en              (rd_en),
        .rd_data            (rd_data),
        .fetch_priority     (fetch_priority),
        .writeback_priority (writeback_priority),
        .crc_busy           (crc_busy)
    );

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    // counts edges that see the busy output high
    always @(posedge core_clk) begin
        if (crc_busy === 1'b1) busy_cnt++;
    end

    // ------------------------------------------------------------
    // reference arithmetic, kept apart from the design's own
    // ------------------------------------------------------------
    function automatic logic [31:0] rev(input logic [31:0] v);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = v[31 - i];
        return r;
    endfunction

    // bytes low first; 32-bit mode takes each byte lsb first
    function automatic logic [31:0] ref_crc(input logic [31:0] c,
        input logic [31:0] dt, input int b, input int p);
        int   nb;
        logic bt;
        logic fb;
        nb = (b == 0) ? 1 : ((b == 1) ? 2 : 4);
        for (int k = 0; k < nb; k++) begin
            for (int i = 0; i < 8; i++) begin
                bt = p ? dt[8*k + i] : dt[8*k + 7 - i];
                fb = (p ? c[31] : c[15]) ^ bt;
                c  = {c[30:0], 1'b0};
                if (fb) c = c ^ (p ? `DCQ_POLY32 : `DCQ_POLY16);
            end
        end
        if (p == 0) c = {16'h0, c[15:0]};
        return c;
    endfunction

    // ------------------------------------------------------------
    // bus tasks: the write strobe stays up until the next task or step
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
    endtask

    task automatic step();
        @(posedge core_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge core_clk);
        addr  <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(negedge core_clk);
        `CHK("rd_data", ex, rd_data)
    endtask

    // waits for two idle cycles in a row, bounded
    task automatic wait_idle();
        int lows;
        lows = 0;
        step();
        for (int i = 0; i < 30 && lows < 2; i++) begin
            @(negedge core_clk);
            lows = (crc_busy === 1'b0) ? lows + 1 : 0;
        end
        if (lows < 2) begin
            n_errors++;
            $display("ERROR busy_wait exp 0 got %b", crc_busy);
            close_out();
        end
    endtask

    task automatic close_out();
        $display("TB: checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // reset state and unmapped read
        @(negedge core_clk);
        `CHK("busy", 1'b0, crc_busy)
        `CHK("fetch", 2'h0, fetch_priority)
        rd(8'h08, 32'h0);
        rd(8'h1c, 32'h0);
        $display("TB: test reset done");
        // every priority code on both fields
        for (int q = 0; q < 4; q++) begin
            wr(`DCQ_OFF_QOS, {28'h0, q[1:0], 2'(3 - q)});
            step();
            @(negedge core_clk);
            `CHK("fetch", q[1:0], fetch_priority)
            `CHK("wback", 2'(3 - q), writeback_priority)
        end
        $display("TB: test priority done");
        // seed while disabled, refused while enabled
        wr(`DCQ_OFF_CTRL, 32'h0);
        wr(`DCQ_OFF_CHKSUM, 32'hffffffff);
        rd(8'h08, 32'hffffffff);
        wr(`DCQ_OFF_CTRL, 32'h1);
        wr(`DCQ_OFF_CHKSUM, 32'h12345678);
        rd(8'h08, 32'hffffffff);
        wr(`DCQ_OFF_CTRL, 32'h0);
        busy_cnt = 0;
        wr(`DCQ_OFF_DATAIN, 32'h000000a5);
        rd(8'h0c, 32'h000000a5);
        // let a false start reach the busy pin count
        @(negedge core_clk);
        `CHK("idle_cnt", 0, busy_cnt)
        $display("TB: test seed done");
        // both polynomials, every beat size
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < 4; b++) begin
                s = 32'hffffffff ^ (b << 4);
                d = 32'h3c5a96e1 + b;
                wr(`DCQ_OFF_CTRL, 32'(p << 1));
                wr(`DCQ_OFF_CHKSUM, s);
                wr(`DCQ_OFF_CTRL, 32'(1 | (p << 1) | (b << 2)));
                busy_cnt = 0;
                wr(`DCQ_OFF_DATAIN, d);
                if (b >= 2) rd(8'h08, s);
                wait_idle();
                `CHK("busy_cnt", b + 1, busy_cnt)
                e = ref_crc(s, d, b, p);
                rd(8'h08, p ? ~rev(e) : e);
            end
        end
        $display("TB: test checksum done");
        // abort in mid update keeps the seed
        s = 32'h0f1e2d3c;
        wr(`DCQ_OFF_CTRL, 32'he);
        wr(`DCQ_OFF_CHKSUM, s);
        wr(`DCQ_OFF_CTRL, 32'hf);
        wr(`DCQ_OFF_DATAIN, 32'h11223344);
        rd(8'h04, 32'h1);
        wr(`DCQ_OFF_CTRL, 32'he);
        wait_idle();
        rd(8'h08, ~rev(s));
        $display("TB: test abort done");
        close_out();
    end
endmodule
